// file: ccfg_pkg.sv
// Package with offsets, field positions, reset values and encodings of the config bank.
`default_nettype none
package ccfg_pkg;
	localparam logic [7:0] XLATE_DEST_SECOND_OFS         = 8'h0c;
	localparam logic [7:0] BRIDGE_TIMING_CONFIG_OFS      = 8'h0d;
	localparam logic [7:0] REVERSE_RX_AND_PIN_ENABLE_OFS = 8'h0e;

	localparam int XLATE_DEST_ADDR_LSB    = 1;
	localparam int LOCAL_ACK_BIT          = 7;
	localparam int SLAVE_SETUP_HOLD_LSB   = 5;
	localparam int MASTER_BIT_RATE_LSB    = 2;
	localparam int SLAVE_TIMEOUT_LSB      = 0;
	localparam int REV_RX_POS_BIT         = 7;
	localparam int REV_RX_NEG_BIT         = 6;
	localparam int PIN1_ENABLE_BIT        = 1;
	localparam int PIN_ENABLE_LSB         = 1;

	localparam logic [6:0] XLATE_DEST_ADDR_RST  = 7'h00;
	localparam logic       LOCAL_ACK_RST        = 1'h1;
	localparam logic [1:0] SLAVE_SETUP_HOLD_RST = 2'h1;
	localparam logic [2:0] MASTER_BIT_RATE_RST  = 3'h5;
	localparam logic [1:0] SLAVE_TIMEOUT_RST    = 2'h2;
	localparam logic       REV_RX_POS_RST       = 1'h0;
	localparam logic       REV_RX_NEG_RST       = 1'h1;
	localparam logic [4:0] PIN_ENABLE_RST       = 5'h01;

	// Slave remote timeout in microseconds, and its cycle count at 25 MHz.
	localparam int CLK_MHZ         = 25;
	localparam int TIMEOUT_US_0    = 64;
	localparam int TIMEOUT_US_1    = 256;
	localparam int TIMEOUT_US_2    = 1024;
	localparam logic [1:0] TIMEOUT_OFF = 2'h3;
	localparam int TIMEOUT_CYC_0   = TIMEOUT_US_0 * CLK_MHZ;
	localparam int TIMEOUT_CYC_1   = TIMEOUT_US_1 * CLK_MHZ;
	localparam int TIMEOUT_CYC_2   = TIMEOUT_US_2 * CLK_MHZ;

	// Setup and hold times in ns, per slave timing code.
	localparam int SETUP_NS_0 = 352;
	localparam int SETUP_NS_1 = 469;
	localparam int SETUP_NS_2 = 938;
	localparam int SETUP_NS_3 = 1046;
	localparam int HOLD_NS_0  = 117;
	localparam int HOLD_NS_1  = 234;
	localparam int HOLD_NS_2  = 352;
	localparam int HOLD_NS_3  = 469;
	localparam int CLK_NS     = 40;

	// Master bit rate per code in hundredths of kbps, and the clock in the same unit.
	// Hundredths keep the slowest rate exact instead of rounding it.
	localparam int RATE_DK_0 = 847;
	localparam int RATE_DK_1 = 2830;
	localparam int RATE_DK_2 = 8470;
	localparam int RATE_DK_3 = 10500;
	localparam int RATE_DK_4 = 17300;
	localparam int RATE_DK_5 = 33900;
	localparam int RATE_DK_6 = 53300;
	localparam int RATE_DK_7 = 83700;
	localparam int CLK_DKHZ  = 2500000;
endpackage
`default_nettype wire

// file: ccfg_regs.sv
// Configuration bank for translator destination, bridge timing and pin enables.
`default_nettype none
// How it works
// RULE_01 - Register xlate_dest_second bits 7:1 hold second translator destination, reset zero.
// RULE_02 - Local-ack bit set acknowledges locally when forward channel absent; reset one.
// RULE_03 - Two-bit field picks slave setup/hold time; reset code 01.
// RULE_04 - Three-bit field picks master bit rate from eight values; reset 101.
// RULE_05 - Two-bit field picks slave remote timeout, code 11 disables; reset 10.
// RULE_06 - Positive reverse receiver disable bit, one turns off, resets zero.
// RULE_07 - Negative reverse receiver disable bit, one turns off, resets one.
// RULE_08 - Pin 1 enable bit resets to one.
// RULE_09 - Pin 2..5 enable bits in bits 2..5, reset zero.
// RULE_10 - Software keeps reserved bit 0 zero in registers xlate_dest_second and reverse_rx_and_pin_enable.
module ccfg_regs (
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic       regWrite,
	input  wire logic [7:0] regAddr,
	input  wire logic [7:0] regWdata,
	output logic      [7:0] regRdata,
	output logic      [6:0] xlateDestAddrSecond,
	output logic            localAckEnable,
	output logic      [1:0] slaveSetupHoldSel,
	output logic      [2:0] masterBitRateSel,
	output logic      [1:0] slaveRemoteTimeoutSel,
	output logic            revRxPosEnable,
	output logic            revRxNegEnable,
	output logic      [4:0] pinEnable,
	output logic     [15:0] setupCycles,
	output logic     [15:0] holdCycles,
	output logic     [15:0] bitHalfCycles,
	output logic     [15:0] timeoutCycles,
	output logic            timeoutEnable
);
	import ccfg_pkg::*;

	typedef struct packed {
		logic [6:0]  dest;
		logic        locAck;
		logic [1:0]  setHold;
		logic [2:0]  rate;
		logic [1:0]  tmo;
		logic        revPosDis;
		logic        revNegDis;
		logic [4:0]  pinEn;
		logic [7:0]  rdata;
		logic [15:0] setupCyc;
		logic [15:0] holdCyc;
		logic [15:0] halfCyc;
		logic [15:0] tmoCyc;
	} ccfg_state_t;

	ccfg_state_t state_q;
	ccfg_state_t state_d;

	// Least times round up to whole cycles.
	function automatic logic [15:0] nsToCycles(input int ns);
		nsToCycles = 16'((ns + CLK_NS - 1) / CLK_NS);
	endfunction

	// Half a bit period, rounded down but never below one cycle.
	function automatic logic [15:0] halfBitCycles(input int rateDk);
		int c;
		c = CLK_DKHZ / (2 * rateDk);
		halfBitCycles = (c < 1) ? 16'h0001 : 16'(c);
	endfunction

	always_comb begin
		state_d = state_q;
		if (regWrite) begin
			case (regAddr)
				XLATE_DEST_SECOND_OFS: begin
					// RULE_01 destination address store.
					state_d.dest = regWdata[7:XLATE_DEST_ADDR_LSB];
				end
				BRIDGE_TIMING_CONFIG_OFS: begin
					// RULE_02 local acknowledge store.
					state_d.locAck  = regWdata[LOCAL_ACK_BIT];
					state_d.setHold = regWdata[SLAVE_SETUP_HOLD_LSB +: 2];
					state_d.rate    = regWdata[MASTER_BIT_RATE_LSB +: 3];
					state_d.tmo     = regWdata[SLAVE_TIMEOUT_LSB +: 2];
				end
				REVERSE_RX_AND_PIN_ENABLE_OFS: begin
					// RULE_06 positive receiver disable.
					state_d.revPosDis = regWdata[REV_RX_POS_BIT];
					// RULE_07 negative receiver disable.
					state_d.revNegDis = regWdata[REV_RX_NEG_BIT];
					// RULE_08 pin enables store.
					state_d.pinEn     = regWdata[PIN_ENABLE_LSB +: 5];
				end
				default: begin
					state_d.dest = state_q.dest;
				end
			endcase
		end
		// Reads are registered; reserved bits read back as zero.
		case (regAddr)
			XLATE_DEST_SECOND_OFS: begin
				state_d.rdata = {state_q.dest, 1'b0};
			end
			BRIDGE_TIMING_CONFIG_OFS: begin
				state_d.rdata = {state_q.locAck, state_q.setHold, state_q.rate, state_q.tmo};
			end
			REVERSE_RX_AND_PIN_ENABLE_OFS: begin
				// RULE_09 pins 2..5 in bits 2..5.
				state_d.rdata = {state_q.revPosDis, state_q.revNegDis, state_q.pinEn, 1'b0};
			end
			default: begin
				state_d.rdata = 8'h00;
			end
		endcase
		// RULE_03 setup/hold decode.
		case (state_q.setHold)
			2'h0: begin
				state_d.setupCyc = nsToCycles(SETUP_NS_0);
				state_d.holdCyc  = nsToCycles(HOLD_NS_0);
			end
			2'h1: begin
				state_d.setupCyc = nsToCycles(SETUP_NS_1);
				state_d.holdCyc  = nsToCycles(HOLD_NS_1);
			end
			2'h2: begin
				state_d.setupCyc = nsToCycles(SETUP_NS_2);
				state_d.holdCyc  = nsToCycles(HOLD_NS_2);
			end
			default: begin
				state_d.setupCyc = nsToCycles(SETUP_NS_3);
				state_d.holdCyc  = nsToCycles(HOLD_NS_3);
			end
		endcase
		// RULE_04 bit rate decode.
		case (state_q.rate)
			3'h0: state_d.halfCyc = halfBitCycles(RATE_DK_0);
			3'h1: state_d.halfCyc = halfBitCycles(RATE_DK_1);
			3'h2: state_d.halfCyc = halfBitCycles(RATE_DK_2);
			3'h3: state_d.halfCyc = halfBitCycles(RATE_DK_3);
			3'h4: state_d.halfCyc = halfBitCycles(RATE_DK_4);
			3'h5: state_d.halfCyc = halfBitCycles(RATE_DK_5);
			3'h6: state_d.halfCyc = halfBitCycles(RATE_DK_6);
			default: state_d.halfCyc = halfBitCycles(RATE_DK_7);
		endcase
		// RULE_05 timeout decode, zero when disabled.
		case (state_q.tmo)
			2'h0: state_d.tmoCyc = 16'(TIMEOUT_CYC_0);
			2'h1: state_d.tmoCyc = 16'(TIMEOUT_CYC_1);
			2'h2: state_d.tmoCyc = 16'(TIMEOUT_CYC_2);
			default: state_d.tmoCyc = 16'h0000;
		endcase
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_q.dest      <= XLATE_DEST_ADDR_RST;
			state_q.locAck    <= LOCAL_ACK_RST;
			state_q.setHold   <= SLAVE_SETUP_HOLD_RST;
			state_q.rate      <= MASTER_BIT_RATE_RST;
			state_q.tmo       <= SLAVE_TIMEOUT_RST;
			state_q.revPosDis <= REV_RX_POS_RST;
			state_q.revNegDis <= REV_RX_NEG_RST;
			state_q.pinEn     <= PIN_ENABLE_RST;
			state_q.rdata     <= 8'h00;
			// Derived counts start as the decode of the reset codes; after a write they follow the codes one cycle late.
			state_q.setupCyc  <= nsToCycles(SETUP_NS_1);
			state_q.holdCyc   <= nsToCycles(HOLD_NS_1);
			state_q.halfCyc   <= halfBitCycles(RATE_DK_5);
			state_q.tmoCyc    <= 16'(TIMEOUT_CYC_2);
		end else begin
			state_q <= state_d;
		end
	end

	assign regRdata              = state_q.rdata;
	assign xlateDestAddrSecond   = state_q.dest;
	assign localAckEnable        = state_q.locAck;
	assign slaveSetupHoldSel     = state_q.setHold;
	assign masterBitRateSel      = state_q.rate;
	assign slaveRemoteTimeoutSel = state_q.tmo;
	assign revRxPosEnable        = ~state_q.revPosDis;
	assign revRxNegEnable        = ~state_q.revNegDis;
	assign pinEnable             = state_q.pinEn;
	assign setupCycles           = state_q.setupCyc;
	assign holdCycles            = state_q.holdCyc;
	assign bitHalfCycles         = state_q.halfCyc;
	assign timeoutCycles         = state_q.tmoCyc;
	assign timeoutEnable         = (state_q.tmo != TIMEOUT_OFF);
endmodule
`default_nettype wire

// file: ccfg_regs_properties.sv
// Checker for write effects, reset values and derived timing counts of the bank.
`default_nettype none
module ccfg_regs_chk (
	input wire logic        clk,
	input wire logic        reset,
	input wire logic        regWrite,
	input wire logic [7:0]  regAddr,
	input wire logic [7:0]  regWdata,
	input wire logic [6:0]  xlateDestAddrSecond,
	input wire logic        localAckEnable,
	input wire logic [1:0]  slaveSetupHoldSel,
	input wire logic [2:0]  masterBitRateSel,
	input wire logic [1:0]  slaveRemoteTimeoutSel,
	input wire logic        revRxPosEnable,
	input wire logic        revRxNegEnable,
	input wire logic [4:0]  pinEnable,
	input wire logic [15:0] setupCycles,
	input wire logic [15:0] bitHalfCycles,
	input wire logic [15:0] timeoutCycles,
	input wire logic        timeoutEnable
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	wire logic wrDest = regWrite && regAddr == 8'h0c;
	wire logic wrTime = regWrite && regAddr == 8'h0d;
	wire logic wrPins = regWrite && regAddr == 8'h0e;
	property p_dest; wrDest |=> xlateDestAddrSecond == $past(regWdata[7:1]); endproperty
	a_dest: assert property (p_dest) else $error("dest not loaded");
	property p_ack; wrTime |=> localAckEnable == $past(regWdata[7]); endproperty
	a_ack: assert property (p_ack) else $error("ack bit not loaded");
	property p_fld; wrTime |=> {slaveSetupHoldSel, masterBitRateSel,
		slaveRemoteTimeoutSel} == $past(regWdata[6:0]); endproperty
	a_fld: assert property (p_fld) else $error("timing fields not loaded");
	property p_sh; slaveSetupHoldSel == 2'h3 |=> setupCycles == 16'h1b; endproperty
	a_sh: assert property (p_sh) else $error("setup count wrong");
	property p_rate; masterBitRateSel == 3'h7 |=> bitHalfCycles == 16'he; endproperty
	a_rate: assert property (p_rate) else $error("bit rate count wrong");
	property p_tmo; slaveRemoteTimeoutSel == 2'h3 |-> !timeoutEnable ##1 timeoutCycles == 0; endproperty
	a_tmo: assert property (p_tmo) else $error("timeout not off");
	property p_en; wrPins |=> !revRxPosEnable == $past(regWdata[7]) &&
		!revRxNegEnable == $past(regWdata[6]) && pinEnable == $past(regWdata[5:1]); endproperty
	a_en: assert property (p_en) else $error("enables not loaded");
	property p_rst; $fell(reset) |-> localAckEnable && revRxPosEnable && !revRxNegEnable &&
		pinEnable == 5'h01 && xlateDestAddrSecond == 7'h00; endproperty
	a_rst: assert property (p_rst) else $error("bad reset value");
endmodule
bind ccfg_regs ccfg_regs_chk u_chk (.*);
`default_nettype wire

// file: ccfg_host.sv
// Control-channel host model issuing register writes and reads.
`default_nettype none
module ccfg_host (
	input  wire logic       clk,
	input  wire logic [7:0] regRdata,
	output var  logic       regWrite,
	output var  logic [7:0] regAddr,
	output var  logic [7:0] regWdata
);
	timeunit 1ns;
	timeprecision 1ns;
	initial {regWrite, regAddr, regWdata} = '0;
	task automatic wr(input logic [7:0] a, d, input bit raw = 0);
		@(posedge clk);
		{regWrite, regAddr} <= {1'h1, a};
		regWdata <= (a == 8'h0c || a == 8'h0e) && !raw ? d & 8'hfe : d;
		@(posedge clk);
		regWrite <= 1'h0;
		#1;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		regAddr <= a;
		@(posedge clk);
		#1 d = regRdata;
	endtask
endmodule
`default_nettype wire

// file: control_channel_config_regs_tb_top.sv
// Self-checking bench for the configuration register bank.
`default_nettype none
module control_channel_config_regs_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {logic [7:0] w; logic [63:0] c;} ccfg_row_t;
	ccfg_row_t rows [8] = '{
		'{8'h00, 64'h0009_0003_05c3_0640}, '{8'ha5, 64'h000c_0006_01b9_1900},
		'{8'h4a, 64'h0018_0009_0093_6400}, '{8'hef, 64'h001b_000c_0077_0000},
		'{8'h10, 64'h0009_0003_0048_0640}, '{8'hb5, 64'h000c_0006_0024_1900},
		'{8'h5a, 64'h0018_0009_0017_6400}, '{8'hff, 64'h001b_000c_000e_0000}};
	logic        clk = 1'h0;
	logic        reset = 1'h1;
	logic        regWrite, localAckEnable, revRxPosEnable, revRxNegEnable, timeoutEnable;
	logic [7:0]  regAddr, regWdata, regRdata, rdVal;
	logic [6:0]  xlateDestAddrSecond;
	logic [4:0]  pinEnable;
	logic [2:0]  masterBitRateSel;
	logic [1:0]  slaveSetupHoldSel, slaveRemoteTimeoutSel;
	logic [15:0] setupCycles, holdCycles, bitHalfCycles, timeoutCycles;
	int          mismatches = 0;
	int          checks = 0;
	ccfg_regs DUT (.*);
	ccfg_host host (.*);
	task chk(input logic [63:0] g, e);
		checks++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task conclude;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task dflt;
		host.rd(8'h0d, rdVal);
		chk({rdVal, xlateDestAddrSecond, revRxPosEnable, revRxNegEnable, pinEnable},
			22'h2d8041);
		host.rd(8'h0e, rdVal);
		chk(rdVal, 8'h42);
		chk({setupCycles, holdCycles, bitHalfCycles, timeoutCycles}, 64'h000c_0006_0024_6400);
	endtask
	initial forever #20 clk = ~clk;
	initial begin
		repeat (6) @(posedge clk);
		reset <= 1'h0;
		dflt();
		foreach (rows[i]) begin
			host.wr(8'h0d, rows[i].w);
			host.rd(8'h0d, rdVal);
			chk({rdVal, localAckEnable, slaveSetupHoldSel, masterBitRateSel,
				slaveRemoteTimeoutSel}, {2{rows[i].w}});
			chk({setupCycles, holdCycles, bitHalfCycles, timeoutCycles}, rows[i].c);
			chk(timeoutEnable, rows[i].w[1:0] != 2'h3);
		end
		host.wr(8'h0c, 8'hff, 1'h1);
		host.wr(8'h0e, 8'hff, 1'h1);
		chk({xlateDestAddrSecond, revRxPosEnable, revRxNegEnable, pinEnable}, 14'h3f9f);
		host.rd(8'h0c, rdVal);
		chk(rdVal, 8'hfe);
		host.wr(8'h0e, 8'h00);
		host.wr(8'h0f, 8'hff);
		host.rd(8'h0f, rdVal);
		chk({revRxPosEnable, revRxNegEnable, pinEnable, rdVal}, 15'h6000);
		@(posedge clk) reset <= 1'h1;
		@(posedge clk) reset <= 1'h0;
		dflt();
		conclude();
	end
endmodule
`default_nettype wire
